// >>> logic/difg_pkg.sv
package difg_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int CLK_PERIOD_NS = 10;
  // Cycles in one microsecond, the unit of every delay below
  localparam int CYCLES_PER_US = 1000 / CLK_PERIOD_NS;
  localparam int US_WIDTH = 14;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_OVER_THRESHOLD = 8'h40;
  localparam logic [7:0] ADDR_OVER_HYSTERESIS = 8'h41;
  localparam logic [7:0] ADDR_UNDER_THRESHOLD = 8'h42;
  localparam logic [7:0] ADDR_UNDER_HYSTERESIS = 8'h43;
  localparam logic [7:0] ADDR_DETECTOR_CONFIG = 8'h44;
  localparam logic [7:0] ADDR_FUNCTION_SELECT = 8'h45;
  localparam logic [7:0] ADDR_LOGIC_INPUT_CONFIG = 8'h46;

  // ----------------------------------------------------------------
  // Writable bits and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_THRESHOLD = 8'hFF;
  localparam logic [7:0] MASK_HYSTERESIS = 8'h1F;
  localparam logic [7:0] MASK_DETECTOR_CONFIG = 8'h1F;
  localparam logic [7:0] MASK_FUNCTION_SELECT = 8'h03;
  localparam logic [7:0] MASK_LOGIC_INPUT_CONFIG = 8'h7F;
  localparam logic [7:0] RESET_OVER_THRESHOLD = 8'hFF;
  localparam logic [7:0] RESET_UNDER_THRESHOLD = 8'h00;
  localparam logic [7:0] RESET_HYSTERESIS = 8'h00;
  localparam logic [7:0] RESET_DETECTOR_CONFIG = 8'h03;
  localparam logic [7:0] RESET_FUNCTION_SELECT = 8'h03;
  localparam logic [7:0] RESET_LOGIC_INPUT_CONFIG = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_DET_GLITCH = 2;
  localparam int POS_FAULT_TYPE = 0;
  localparam int POS_INPUT_INVERT = 6;
  localparam int POS_DETECT_TYPE = 5;
  localparam int POS_PULSE_LENGTH = 3;
  localparam int POS_LOGIC_GLITCH = 0;

  // ----------------------------------------------------------------
  // Delays in microseconds
  // ----------------------------------------------------------------
  localparam logic [US_WIDTH-1:0] GLITCH_US_0 = 14'h0000;
  localparam logic [US_WIDTH-1:0] GLITCH_US_1 = 14'h0005;
  localparam logic [US_WIDTH-1:0] GLITCH_US_2 = 14'h000A;
  localparam logic [US_WIDTH-1:0] GLITCH_US_3 = 14'h0014;
  localparam logic [US_WIDTH-1:0] GLITCH_US_4 = 14'h001E;
  localparam logic [US_WIDTH-1:0] GLITCH_US_5 = 14'h0032;
  localparam logic [US_WIDTH-1:0] GLITCH_US_6 = 14'h004B;
  localparam logic [US_WIDTH-1:0] GLITCH_US_7 = 14'h0064;
  localparam logic [US_WIDTH-1:0] PULSE_US_0 = 14'h0000;
  localparam logic [US_WIDTH-1:0] PULSE_US_1 = 14'h0064;
  localparam logic [US_WIDTH-1:0] PULSE_US_2 = 14'h03E8;
  localparam logic [US_WIDTH-1:0] PULSE_US_3 = 14'h2710;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FT_OVER = 2'h0,
    FT_EITHER = 2'h1,
    FT_UNDER = 2'h2,
    FT_OFF = 2'h3
  } difg_fault_type_e;

  typedef enum logic [1:0] {
    FN_DETECTOR = 2'h0,
    FN_LOGIC = 2'h1,
    FN_LOGIC_WARN = 2'h2,
    FN_NONE = 2'h3
  } difg_function_e;

  typedef enum logic [1:0] {
    PS_IDLE = 2'b01,
    PS_PULSE = 2'b10
  } difg_pulse_e;

  typedef struct packed {
    logic fault;
    logic warning;
    logic overVoltageFlag;
    logic underVoltageFlag;
  } difg_out_s;

  function automatic logic [US_WIDTH-1:0] glitch_us(input logic [2:0] code);
    case (code)
      3'h0: glitch_us = GLITCH_US_0;
      3'h1: glitch_us = GLITCH_US_1;
      3'h2: glitch_us = GLITCH_US_2;
      3'h3: glitch_us = GLITCH_US_3;
      3'h4: glitch_us = GLITCH_US_4;
      3'h5: glitch_us = GLITCH_US_5;
      3'h6: glitch_us = GLITCH_US_6;
      default: glitch_us = GLITCH_US_7;
    endcase
  endfunction

  function automatic logic [US_WIDTH-1:0] pulse_us(input logic [1:0] code);
    case (code)
      2'h0: pulse_us = PULSE_US_0;
      2'h1: pulse_us = PULSE_US_1;
      2'h2: pulse_us = PULSE_US_2;
      default: pulse_us = PULSE_US_3;
    endcase
  endfunction

endpackage

// >>> logic/difg_glitch_filter.sv
module difg_glitch_filter #(
  parameter int US_WIDTH = difg_pkg::US_WIDTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic usTick,
  input wire logic [US_WIDTH-1:0] delayUs,
  input wire logic din,
  output logic dout
);

  logic [US_WIDTH-1:0] stableCount;
  logic [US_WIDTH-1:0] next_stableCount;
  wire differs = (din != dout);
  wire expired = (delayUs == '0) || (usTick && (next_stableCount >= delayUs));

  assign next_stableCount = stableCount + US_WIDTH'(1);

  // A level must hold, unbroken, through delayUs microsecond ticks before it passes; the first is partial
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dout <= 1'b0;
      stableCount <= '0;
    end else if (!differs) begin
      stableCount <= '0;
    end else if (expired) begin
      dout <= din;
      stableCount <= '0;
    end else if (usTick) begin
      stableCount <= next_stableCount;
    end
  end

  property p_filter_follows;
    @(posedge sys_clk) disable iff (rst)
    $changed(dout) |-> ($past(din) == dout);
  endproperty
  a_filter_follows: assert property (p_filter_follows)
    else $error("filter output moved without its input");

  property p_filter_zero_delay;
    @(posedge sys_clk) disable iff (rst)
    (delayUs == '0) |=> (dout == $past(din));
  endproperty
  a_filter_zero_delay: assert property (p_filter_zero_delay)
    else $error("zero delay filter did not pass input");

endmodule // difg_glitch_filter

// >>> logic/difg_channel.sv
module difg_channel #(
  parameter int TICK_CYCLES = difg_pkg::CYCLES_PER_US
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic [7:0] levelCode,
  input wire logic logicPin,
  output difg_pkg::difg_out_s chanOut
);

  localparam int TICK_WIDTH = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam int UW = difg_pkg::US_WIDTH;

  // ----------------------------------------------------------------
  // Microsecond time base
  // ----------------------------------------------------------------
  logic [TICK_WIDTH-1:0] tickCount;
  wire usTick = (tickCount == TICK_WIDTH'(TICK_CYCLES - 1));

  always_ff @(posedge sys_clk) begin
    if (rst || usTick) begin
      tickCount <= '0;
    end else begin
      tickCount <= tickCount + TICK_WIDTH'(1);
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] overThreshold;
  logic [7:0] overHysteresis;
  logic [7:0] underThreshold;
  logic [7:0] underHysteresis;
  logic [7:0] detectorConfig;
  logic [7:0] channelFunctionSelect;
  logic [7:0] logicInputConfig;
  logic [7:0] next_regRdData;

  wire selOverTh = (regAddr == difg_pkg::ADDR_OVER_THRESHOLD);
  wire selOverHy = (regAddr == difg_pkg::ADDR_OVER_HYSTERESIS);
  wire selUnderTh = (regAddr == difg_pkg::ADDR_UNDER_THRESHOLD);
  wire selUnderHy = (regAddr == difg_pkg::ADDR_UNDER_HYSTERESIS);
  wire selDetCfg = (regAddr == difg_pkg::ADDR_DETECTOR_CONFIG);
  wire selFunc = (regAddr == difg_pkg::ADDR_FUNCTION_SELECT);
  wire selLogCfg = (regAddr == difg_pkg::ADDR_LOGIC_INPUT_CONFIG);

  // Unusable bits are never stored, so they read back as zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      overThreshold <= difg_pkg::RESET_OVER_THRESHOLD;
      overHysteresis <= difg_pkg::RESET_HYSTERESIS;
      underThreshold <= difg_pkg::RESET_UNDER_THRESHOLD;
      underHysteresis <= difg_pkg::RESET_HYSTERESIS;
      detectorConfig <= difg_pkg::RESET_DETECTOR_CONFIG;
      channelFunctionSelect <= difg_pkg::RESET_FUNCTION_SELECT;
      logicInputConfig <= difg_pkg::RESET_LOGIC_INPUT_CONFIG;
    end else if (regWrEn) begin
      if (selOverTh) overThreshold <= regWrData & difg_pkg::MASK_THRESHOLD;
      if (selOverHy) overHysteresis <= regWrData & difg_pkg::MASK_HYSTERESIS;
      if (selUnderTh) underThreshold <= regWrData & difg_pkg::MASK_THRESHOLD;
      if (selUnderHy) underHysteresis <= regWrData & difg_pkg::MASK_HYSTERESIS;
      if (selDetCfg) detectorConfig <= regWrData & difg_pkg::MASK_DETECTOR_CONFIG;
      if (selFunc) channelFunctionSelect <= regWrData & difg_pkg::MASK_FUNCTION_SELECT;
      if (selLogCfg) logicInputConfig <= regWrData & difg_pkg::MASK_LOGIC_INPUT_CONFIG;
    end
  end

  // Unmapped offsets read as zero
  assign next_regRdData = ({8{selOverTh}} & overThreshold)
                        | ({8{selOverHy}} & overHysteresis)
                        | ({8{selUnderTh}} & underThreshold)
                        | ({8{selUnderHy}} & underHysteresis)
                        | ({8{selDetCfg}} & detectorConfig)
                        | ({8{selFunc}} & channelFunctionSelect)
                        | ({8{selLogCfg}} & logicInputConfig);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      regRdData <= next_regRdData;
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire [4:0] overHystBits = overHysteresis[4:0];
  wire [4:0] underHystBits = underHysteresis[4:0];
  wire [2:0] detGlitchCode = detectorConfig[difg_pkg::POS_DET_GLITCH +: 3];
  wire [1:0] faultTypeBits = detectorConfig[difg_pkg::POS_FAULT_TYPE +: 2];
  wire [1:0] functionBits = channelFunctionSelect[1:0];
  wire inputInvert = logicInputConfig[difg_pkg::POS_INPUT_INVERT];
  wire detectType = logicInputConfig[difg_pkg::POS_DETECT_TYPE];
  wire [1:0] pulseLengthCode = logicInputConfig[difg_pkg::POS_PULSE_LENGTH +: 2];
  wire [2:0] logicGlitchCode = logicInputConfig[difg_pkg::POS_LOGIC_GLITCH +: 3];
  difg_pkg::difg_fault_type_e faultType;
  difg_pkg::difg_function_e functionCode;
  assign faultType = difg_pkg::difg_fault_type_e'(faultTypeBits);
  assign functionCode = difg_pkg::difg_function_e'(functionBits);

  // ----------------------------------------------------------------
  // Supply fault detector
  // ----------------------------------------------------------------
  logic overFlag;
  logic underFlag;
  logic detRaw;
  logic detFiltered;
  logic [7:0] overLimit;
  logic [7:0] underLimit;
  wire [8:0] underSum = {1'b0, underThreshold} + {4'h0, underHystBits};
  wire [7:0] overDiff = overThreshold - {3'h0, overHystBits};
  wire overUnderflow = ({3'h0, overHystBits} > overThreshold);

  // Saturate so a large hysteresis cannot wrap the limit around
  assign overLimit = overFlag ? (overUnderflow ? 8'h00 : overDiff) : overThreshold;
  assign underLimit = underFlag ? (underSum[8] ? 8'hFF : underSum[7:0]) : underThreshold;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      overFlag <= 1'b0;
      underFlag <= 1'b0;
    end else begin
      overFlag <= (levelCode > overLimit);
      underFlag <= (levelCode < underLimit);
    end
  end

  always_comb begin
    case (faultType)
      difg_pkg::FT_OVER: detRaw = overFlag;
      difg_pkg::FT_EITHER: detRaw = overFlag | underFlag;
      difg_pkg::FT_UNDER: detRaw = underFlag;
      default: detRaw = 1'b0;
    endcase
  end

  difg_glitch_filter #(
    .US_WIDTH(UW)
  ) u_det_filter (
    .sys_clk(sys_clk),
    .rst(rst),
    .usTick(usTick),
    .delayUs(difg_pkg::glitch_us(detGlitchCode)),
    .din(detRaw),
    .dout(detFiltered)
  );

  // ----------------------------------------------------------------
  // Logic input
  // ----------------------------------------------------------------
  logic logicFiltered;
  logic logicPrev;
  wire logicInverted = logicPin ^ inputInvert;
  wire logicEdge = logicFiltered & ~logicPrev;

  // Inversion sits ahead of the filter so both see the same polarity
  difg_glitch_filter #(
    .US_WIDTH(UW)
  ) u_logic_filter (
    .sys_clk(sys_clk),
    .rst(rst),
    .usTick(usTick),
    .delayUs(difg_pkg::glitch_us(logicGlitchCode)),
    .din(logicInverted),
    .dout(logicFiltered)
  );

  // ----------------------------------------------------------------
  // Edge pulse generator
  // ----------------------------------------------------------------
  difg_pkg::difg_pulse_e pulseState;
  difg_pkg::difg_pulse_e next_pulseState;
  logic [UW-1:0] pulseLeft;
  logic [UW-1:0] next_pulseLeft;

  // Length is counted in whole microsecond ticks; the first is partial
  always_comb begin
    next_pulseState = pulseState;
    next_pulseLeft = pulseLeft;
    case (pulseState)
      difg_pkg::PS_IDLE: begin
        if (detectType && logicEdge) begin
          next_pulseState = difg_pkg::PS_PULSE;
          next_pulseLeft = difg_pkg::pulse_us(pulseLengthCode);
        end
      end
      difg_pkg::PS_PULSE: begin
        if (pulseLeft == '0) begin
          next_pulseState = difg_pkg::PS_IDLE;
        end else if (usTick) begin
          next_pulseLeft = pulseLeft - UW'(1);
        end
      end
      default: begin
        next_pulseState = difg_pkg::PS_IDLE;
        next_pulseLeft = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pulseState <= difg_pkg::PS_IDLE;
      pulseLeft <= '0;
      logicPrev <= 1'b0;
    end else begin
      pulseState <= next_pulseState;
      pulseLeft <= next_pulseLeft;
      logicPrev <= logicFiltered;
    end
  end

  wire pulseActive = (pulseState == difg_pkg::PS_PULSE);
  wire logicResult = detectType ? pulseActive : logicFiltered;

  // ----------------------------------------------------------------
  // Function routing
  // ----------------------------------------------------------------
  logic next_fault;
  logic next_warning;
  logic faultOut;
  logic warnOut;

  always_comb begin
    next_fault = 1'b0;
    next_warning = 1'b0;
    case (functionCode)
      difg_pkg::FN_DETECTOR: next_fault = detFiltered;
      difg_pkg::FN_LOGIC: next_fault = logicResult;
      difg_pkg::FN_LOGIC_WARN: begin
        next_fault = logicResult;
        next_warning = detFiltered;
      end
      default: next_fault = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      faultOut <= 1'b0;
      warnOut <= 1'b0;
    end else begin
      faultOut <= next_fault;
      warnOut <= next_warning;
    end
  end

  assign chanOut = {faultOut, warnOut, overFlag, underFlag};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_over_hysteresis;
    @(posedge sys_clk) disable iff (rst)
    (overFlag && levelCode <= overThreshold && overHystBits != 5'h00 && !overUnderflow
      && levelCode > overThreshold - {3'h0, overHystBits}) |=> overFlag;
  endproperty
  a_over_hysteresis: assert property (p_over_hysteresis)
    else $error("over flag dropped inside hysteresis band");
  property p_over_set;
    @(posedge sys_clk) disable iff (rst)
    (!overFlag && levelCode > overThreshold) |=> overFlag;
  endproperty
  a_over_set: assert property (p_over_set)
    else $error("over flag not raised above threshold");
  property p_under_set;
    @(posedge sys_clk) disable iff (rst)
    (!underFlag && levelCode < underThreshold) |=> underFlag;
  endproperty
  a_under_set: assert property (p_under_set)
    else $error("under flag not raised below threshold");
  property p_under_hysteresis;
    @(posedge sys_clk) disable iff (rst)
    (underFlag && !underSum[8] && levelCode >= underSum[7:0]) |=> !underFlag;
  endproperty
  a_under_hysteresis: assert property (p_under_hysteresis)
    else $error("under flag held above raised limit");
  property p_type_excludes;
    @(posedge sys_clk) disable iff (rst)
    (faultType == difg_pkg::FT_OVER && !overFlag) |-> !detRaw;
  endproperty
  a_type_excludes: assert property (p_type_excludes)
    else $error("over-only type reported without over flag");
  property p_none_quiet;
    @(posedge sys_clk) disable iff (rst)
    (functionCode == difg_pkg::FN_NONE) |=> (!chanOut.fault && !chanOut.warning);
  endproperty
  a_none_quiet: assert property (p_none_quiet)
    else $error("outputs active with no function");
  property p_warn_role;
    @(posedge sys_clk) disable iff (rst)
    chanOut.warning |-> ($past(functionCode) == difg_pkg::FN_LOGIC_WARN);
  endproperty
  a_warn_role: assert property (p_warn_role)
    else $error("warning raised outside warning role");
  property p_invert_first;
    @(posedge sys_clk) disable iff (rst)
    (logicGlitchCode == 3'h0) |=> (logicFiltered == $past(logicPin ^ inputInvert));
  endproperty
  a_invert_first: assert property (p_invert_first)
    else $error("logic input not inverted ahead of filter");
  property p_edge_starts;
    @(posedge sys_clk) disable iff (rst)
    (detectType && logicEdge && !pulseActive) |=> pulseActive;
  endproperty
  a_edge_starts: assert property (p_edge_starts)
    else $error("edge did not start a pulse");
  property p_pulse_ends;
    @(posedge sys_clk) disable iff (rst)
    (pulseActive && pulseLeft == '0) |=> !pulseActive;
  endproperty
  a_pulse_ends: assert property (p_pulse_ends)
    else $error("pulse ran past its length");
  property p_reserved_zero;
    @(posedge sys_clk) disable iff (rst)
    (regRdEn && selFunc) |=> (regRdData[7:2] == 6'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("unusable bits read nonzero");
endmodule // difg_channel

// >>> bench/dual_input_fault_gpi_config_tb_top.sv
module dual_input_fault_gpi_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Stimulus and design
  // ----------------------------------------------------------------
  // Two cycles a microsecond keeps the longest pulse near 20000 cycles
  localparam int TICK = 2;
  localparam logic [7:0] RV [7] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h03, 8'h03, 8'h00};
  localparam logic [7:0] MK [7] = '{8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'h1F, 8'h03, 8'h7F};
  localparam int GLITCH [8] = '{0, 5, 10, 20, 30, 50, 75, 100};
  localparam int PULSE [4] = '{0, 100, 1000, 10000};

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regRdData;
  logic [7:0] levelCode = 8'h40;
  logic logicPin = 1'b0;
  difg_pkg::difg_out_s chanOut;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;

  always #5 sys_clk = ~sys_clk;

  difg_channel #(.TICK_CYCLES(TICK)) u_dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrEn(regWrEn),
    .regRdEn(regRdEn),
    .regRdData(regRdData),
    .levelCode(levelCode),
    .logicPin(logicPin),
    .chanOut(chanOut)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    @(negedge sys_clk);
    check($sformatf("register %h", a), {8'h00, regRdData}, {8'h00, exp});
  endtask

  // Outputs settle three cycles after an input change with no filter
  task automatic outs(input logic [7:0] lvl, input logic pin, input logic [3:0] exp);
    @(posedge sys_clk);
    levelCode <= lvl;
    logicPin <= pin;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    check("channel outputs", {12'h000, chanOut}, {12'h000, exp});
  endtask

  // Drives a high pulse on the pin or the level and notes any fault
  task automatic glitch(input logic det, input int width, input logic exp);
    logic seen = 1'b0;
    @(posedge sys_clk);
    if (det) levelCode <= 8'h81;
    else logicPin <= 1'b1;
    for (int i = 0; i < 2 * width + 40; i++) begin
      @(posedge sys_clk);
      if (i == width - 1) begin
        levelCode <= 8'h40;
        logicPin <= 1'b0;
      end
      @(negedge sys_clk);
      seen = seen | chanOut.fault;
    end
    check("filtered fault", {15'h0000, seen}, {15'h0000, exp});
  endtask

  task automatic edge_len(input int code);
    int cnt = 0;
    int lo;
    int hi;
    lo = (code == 0) ? 1 : PULSE[code] * TICK;
    hi = (code == 0) ? 1 : (PULSE[code] + 1) * TICK;
    wr(8'h46, 8'h20 | 8'(code << 3));
    @(posedge sys_clk);
    logicPin <= 1'b1;
    for (int i = 0; i < 20 && chanOut.fault !== 1'b1; i++) @(negedge sys_clk);
    while (chanOut.fault === 1'b1 && cnt < 25000) begin
      cnt++;
      @(negedge sys_clk);
    end
    check("pulse length in range", {15'h0000, cnt >= lo && cnt <= hi}, 16'h0001);
    @(posedge sys_clk);
    logicPin <= 1'b0;
    repeat (10) @(posedge sys_clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd(8'h40 + 8'(i), RV[i]);
    rd(8'h47, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(8'h40 + 8'(i), 8'hFF);
      rd(8'h40 + 8'(i), MK[i]);
      wr(8'h40 + 8'(i), 8'h00);
      rd(8'h40 + 8'(i), 8'h00);
    end
    wr(8'h47, 8'hFF);
    rd(8'h47, 8'h00);
    wr(8'h40, 8'h80);
    wr(8'h41, 8'h05);
    wr(8'h42, 8'h20);
    wr(8'h43, 8'h04);
    outs(8'h81, 1'b0, 4'b1010);
    outs(8'h7C, 1'b0, 4'b1010);
    outs(8'h7B, 1'b0, 4'b0000);
    wr(8'h44, 8'h02);
    outs(8'h1F, 1'b0, 4'b1001);
    outs(8'h23, 1'b0, 4'b1001);
    outs(8'h24, 1'b0, 4'b0000);
    for (int t = 0; t < 4; t++) begin
      wr(8'h44, 8'(t));
      outs(8'h81, 1'b0, {t < 2, 3'b010});
      outs(8'h10, 1'b0, {t == 1 || t == 2, 3'b001});
    end
    wr(8'h44, 8'h00);
    for (int f = 0; f < 4; f++) begin
      wr(8'h45, 8'(f));
      outs(8'h81, 1'b0, {f == 0, f == 2, 2'b10});
    end
    wr(8'h45, 8'h01);
    wr(8'h46, 8'h40);
    outs(8'h81, 1'b0, 4'b1010);
    outs(8'h40, 1'b0, 4'b1000);
    outs(8'h40, 1'b1, 4'b0000);
    wr(8'h46, 8'h00);
    outs(8'h40, 1'b1, 4'b1000);
    repeat (100) @(posedge sys_clk);
    outs(8'h40, 1'b1, 4'b1000);
    outs(8'h40, 1'b0, 4'b0000);
    glitch(1'b0, 2, 1'b1);
    for (int g = 1; g < 8; g++) begin
      wr(8'h46, 8'(g));
      glitch(1'b0, (GLITCH[g] - 2) * TICK, 1'b0);
      glitch(1'b0, (GLITCH[g] + 2) * TICK + 4, 1'b1);
    end
    wr(8'h45, 8'h00);
    wr(8'h44, 8'h0C);
    glitch(1'b1, 18 * TICK, 1'b0);
    glitch(1'b1, 22 * TICK + 4, 1'b1);
    wr(8'h45, 8'h01);
    for (int p = 0; p < 4; p++) edge_len(p);
    wrap_up();
  end

endmodule // dual_input_fault_gpi_config_tb_top
